// ==== core/stc_pkg.sv ====
// Purpose: Shared constants and types for the 16-bit timer/counter block
// Assumes: APB slave, 32-bit data, one aligned word per register index
// Notes:   Byte address of a register is four times its index
package stc_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned PRE_W  = 3;
  localparam int unsigned CTL_W  = 6;

  // Register indices; the byte address is the index times four
  localparam logic [7:0] IDX_FLAG   = 8'h0C;
  localparam logic [7:0] IDX_CNT_LO = 8'h0E;
  localparam logic [7:0] IDX_CNT_HI = 8'h0F;
  localparam logic [7:0] IDX_CTL    = 8'h10;
  localparam logic [7:0] IDX_IEN    = 8'h8C;

  localparam logic [ADDR_W-1:0] ADR_FLAG   = ADDR_W'({IDX_FLAG, 2'b00});
  localparam logic [ADDR_W-1:0] ADR_CNT_LO = ADDR_W'({IDX_CNT_LO, 2'b00});
  localparam logic [ADDR_W-1:0] ADR_CNT_HI = ADDR_W'({IDX_CNT_HI, 2'b00});
  localparam logic [ADDR_W-1:0] ADR_CTL    = ADDR_W'({IDX_CTL, 2'b00});
  localparam logic [ADDR_W-1:0] ADR_IEN    = ADDR_W'({IDX_IEN, 2'b00});

  localparam logic [CTL_W-1:0] CTL_RST  = 6'h00;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [PRE_W-1:0] PRE_ZERO = 3'h0;
  localparam int unsigned      FLAG_BIT = 0;

  // Four-phase instruction cycle, one phase per pclk
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // Control register layout, bit 5 down to bit 0
  typedef struct packed {
    logic [1:0] input_prescale_select;
    logic       crystal_osc_enable;
    logic       no_sync_select;
    logic       clock_source_select;
    logic       counter_run;
  } stc_ctl_t;

  typedef struct packed {
    stc_ctl_t           ctl;
    logic [CNT_W-1:0]   cnt;
    logic               overflow_flag;
    logic               overflow_irq_enable;
    logic [1:0]         phase;
    logic               ext_s1;
    logic               ext_s2;
    logic               osc_s1;
    logic               osc_s2;
    logic               pin_prev;
    logic [PRE_W-1:0]   pre;
    logic               pre_out;
    logic               samp;
    logic               pend;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
    logic               irq;
    logic               wake;
    logic [1:0]         pin_oe;
    logic               tbv;
  } stc_state_t;

endpackage

// ==== core/stc_timer.sv ====
// Purpose: 16-bit timer/counter with prescaler, APB registers and sync path
// Assumes: pclk is the oscillator clock; four pclk make one instruction cycle
// Notes:   The count has no reset; software or the capture trigger sets it
//
// Behaviour
// R1: Count pair runs upward 0000h to FFFFh and wraps to 0000h.
// R2: Each wrap sets the overflow flag; interrupt only when its enable is set.
// R3: Source select bit 1: zero instruction clock, one external pin rising edges.
// R4: Run bit 0 set lets the count advance; clear holds the value.
// R5: Prescale field bits 5:4 divides by 1, 2, 4 or 8.
// R6: Oscillator enable forces both oscillator pins to inputs, ignoring direction.
// R7: Counter mode uses oscillator input pin if oscillator enabled, else clock pin.
// R8: Bit 2 zero synchronises external input, one leaves it unsynchronised.
// R9: Prescaler is a ripple counter; synchronisation follows the prescaler output.
// R10: Synchronised mode in sleep: count frozen, prescaler still counts edges.
// R11: Synchroniser samples the prescaler output on phases two and four.
// R12: A synchronised edge increments the count one cycle later.
// R13: Unsynchronised mode keeps counting in sleep; enabled overflow wakes.
// R14: Unsynchronised mode marks the count invalid as capture/compare time base.
// R15: Capture/compare reset input clears the count.
// R16: Control bits 7:6 read zero; bits 5:0 are read/write.
// R17: Writing either count byte clears the prescaler.
// R18: Control resets to 00h: stopped, 1:1 prescale.
// R19: Count is not cleared by device reset, only by the capture trigger.
// R20: Count write beats a coincident capture/compare clear.
// R21: Count byte write loads directly and drops that cycle's increment.
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`default_nettype none

module stc_timer
  import stc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic              ext_clock_pin,
  input  wire logic              osc_input_pin,
  input  wire logic [1:0]        port_dir_oe,
  input  wire logic              sleep_mode,
  input  wire logic              capture_clear,
  output var  logic [CNT_W-1:0]  count_value,
  output var  logic              timebase_valid,
  output var  logic              irq_req,
  output var  logic              wake_req,
  output var  logic [1:0]        osc_pin_oe
);

  stc_state_t st_q;
  stc_state_t st_d;

  logic             setup;
  logic             wr;
  logic             wr_lo;
  logic             wr_hi;
  logic             cnt_wr;
  logic             tick;
  logic             pin_lvl;
  logic             src_ev;
  logic             src_lvl;
  logic             pre_out;
  logic             edge_up;
  logic             sync_mode;
  logic             samp_now;
  logic             s_edge;
  logic             inc;
  logic             ovf;

  always_comb begin
    st_d    = st_q;
    setup   = psel & ~penable;
    wr      = psel & penable & st_q.pready & pwrite;
    wr_lo   = wr && (paddr == ADR_CNT_LO);
    wr_hi   = wr && (paddr == ADR_CNT_HI);
    cnt_wr  = wr_lo | wr_hi;

    // Pin synchronisers; only the second stage is looked at
    st_d.ext_s1 = ext_clock_pin;
    st_d.ext_s2 = st_q.ext_s1;
    st_d.osc_s1 = osc_input_pin;
    st_d.osc_s2 = st_q.osc_s1;
    pin_lvl     = st_q.ctl.crystal_osc_enable ? st_q.osc_s2 : st_q.ext_s2; // [R7]
    st_d.pin_prev = pin_lvl;

    st_d.phase = st_q.phase + 2'h1;
    // Instruction clock stops in sleep like the core's own clock
    tick = (st_q.phase == PH_Q4) & ~sleep_mode;

    src_ev  = st_q.ctl.clock_source_select ? (pin_lvl & ~st_q.pin_prev) : tick; // [R3]
    src_lvl = st_q.ctl.clock_source_select ? pin_lvl : tick;

    // Ripple prescaler modelled as a counter; each bit is one stage output
    if (cnt_wr) begin
      st_d.pre = PRE_ZERO; // [R17]
    end else if (st_q.ctl.counter_run && src_ev) begin
      st_d.pre = st_q.pre + 3'h1; // [R9] [R10]
    end
    case (st_q.ctl.input_prescale_select) // [R5]
      2'h0:    pre_out = src_lvl;
      2'h1:    pre_out = st_q.pre[0];
      2'h2:    pre_out = st_q.pre[1];
      default: pre_out = st_q.pre[2];
    endcase
    st_d.pre_out = pre_out;
    edge_up      = pre_out & ~st_q.pre_out;

    // Synchronised path samples the prescaler output, not the raw pin
    sync_mode = st_q.ctl.clock_source_select & ~st_q.ctl.no_sync_select; // [R8]
    samp_now  = sync_mode & ~sleep_mode
              & ((st_q.phase == PH_Q2) | (st_q.phase == PH_Q4)); // [R11] [R10]
    s_edge    = samp_now & pre_out & ~st_q.samp;
    if (samp_now) begin
      st_d.samp = pre_out; // [R9]
    end
    // Increment lands one cycle after the sampled edge
    st_d.pend = s_edge & st_q.ctl.counter_run; // [R12]

    inc = st_q.ctl.counter_run
        & (sync_mode ? st_q.pend : edge_up); // [R4] [R13]
    ovf = inc & (st_q.cnt == CNT_MAX) & ~cnt_wr & ~capture_clear;

    if (cnt_wr) begin // [R20] [R21]
      if (wr_lo) begin
        st_d.cnt[7:0] = pwdata[7:0];
      end
      if (wr_hi) begin
        st_d.cnt[15:8] = pwdata[7:0];
      end
    end else if (capture_clear) begin
      st_d.cnt = CNT_ZERO; // [R15] [R19]
    end else if (inc) begin
      st_d.cnt = st_q.cnt + 16'h0001; // [R1]
    end

    if (wr && (paddr == ADR_CTL)) begin
      st_d.ctl = stc_ctl_t'(pwdata[CTL_W-1:0]); // [R16]
    end
    if (wr && (paddr == ADR_IEN)) begin
      st_d.overflow_irq_enable = pwdata[FLAG_BIT];
    end
    // A wrap in the clearing cycle keeps the flag set
    if (wr && (paddr == ADR_FLAG)) begin
      st_d.overflow_flag = pwdata[FLAG_BIT];
    end
    if (ovf) begin
      st_d.overflow_flag = 1'b1; // [R2]
    end

    st_d.pready  = setup;
    st_d.pslverr = 1'b0;
    if (setup) begin
      st_d.prdata = 32'h0000_0000;
      if (paddr == ADR_CNT_LO) begin
        st_d.prdata[7:0] = st_q.cnt[7:0];
      end else if (paddr == ADR_CNT_HI) begin
        st_d.prdata[7:0] = st_q.cnt[15:8];
      end else if (paddr == ADR_CTL) begin
        st_d.prdata[CTL_W-1:0] = st_q.ctl; // [R16]
      end else if (paddr == ADR_FLAG) begin
        st_d.prdata[FLAG_BIT] = st_q.overflow_flag;
      end else if (paddr == ADR_IEN) begin
        st_d.prdata[FLAG_BIT] = st_q.overflow_irq_enable;
      end else begin
        st_d.pslverr = 1'b1;
      end
    end else begin
      st_d.pslverr = st_q.pslverr;
    end

    st_d.irq    = st_d.overflow_flag & st_d.overflow_irq_enable; // [R2]
    st_d.wake   = sleep_mode & st_d.irq; // [R13]
    st_d.pin_oe = st_d.ctl.crystal_osc_enable ? 2'b00 : port_dir_oe; // [R6]
    st_d.tbv    = ~(st_d.ctl.clock_source_select & st_d.ctl.no_sync_select); // [R14]
  end

  // The count is left out of reset on purpose so a reset never moves it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.ctl                 <= stc_ctl_t'(CTL_RST); // [R18]
      st_q.overflow_flag       <= 1'b0;
      st_q.overflow_irq_enable <= 1'b0;
      st_q.phase               <= 2'h0;
      st_q.ext_s1              <= 1'b0;
      st_q.ext_s2              <= 1'b0;
      st_q.osc_s1              <= 1'b0;
      st_q.osc_s2              <= 1'b0;
      st_q.pin_prev            <= 1'b0;
      st_q.pre                 <= PRE_ZERO;
      st_q.pre_out             <= 1'b0;
      st_q.samp                <= 1'b0;
      st_q.pend                <= 1'b0;
      st_q.pready              <= 1'b0;
      st_q.pslverr             <= 1'b0;
      st_q.prdata              <= 32'h0000_0000;
      st_q.irq                 <= 1'b0;
      st_q.wake                <= 1'b0;
      st_q.pin_oe              <= 2'b00;
      st_q.tbv                 <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata         = st_q.prdata;
  assign pready         = st_q.pready;
  assign pslverr        = st_q.pslverr;
  assign count_value    = st_q.cnt;
  assign timebase_valid = st_q.tbv;
  assign irq_req        = st_q.irq;
  assign wake_req       = st_q.wake;
  assign osc_pin_oe     = st_q.pin_oe;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sampled_edge;
    s_edge && st_q.ctl.counter_run && !sleep_mode;
  endsequence

  sequence s_clean_step;
    !cnt_wr && !capture_clear;
  endsequence

  a_wrap_to_zero: assert property ( // [R1]
    (inc && st_q.cnt == CNT_MAX && !cnt_wr && !capture_clear) |=> st_q.cnt == CNT_ZERO)
    else $error("count did not wrap to zero");

  a_flag_on_wrap: assert property ( // [R2]
    ovf |=> st_q.overflow_flag ##1 (st_q.irq == st_q.overflow_irq_enable))
    else $error("overflow flag or interrupt wrong after wrap");

  // Case equality: the count is unknown until first loaded and must still read as held
  a_stop_holds: assert property ( // [R4]
    (!st_q.ctl.counter_run && !cnt_wr && !capture_clear) |=> st_q.cnt === $past(st_q.cnt))
    else $error("count moved while stopped");

  a_presc_clear: assert property ( // [R17]
    cnt_wr |=> st_q.pre == PRE_ZERO)
    else $error("prescaler not cleared by count write");

  a_osc_inputs: assert property ( // [R6]
    st_q.ctl.crystal_osc_enable ##1 st_q.ctl.crystal_osc_enable |-> osc_pin_oe == 2'b00)
    else $error("oscillator pin driven while oscillator enabled");

  a_sync_delay: assert property ( // [R12]
    (s_sampled_edge ##1 (s_clean_step and (st_q.ctl.counter_run && sync_mode)))
      |=> st_q.cnt == $past(st_q.cnt) + 16'h0001)
    else $error("synchronised edge did not increment one cycle later");

  a_sync_sleep: assert property ( // [R10]
    (s_clean_step and (sleep_mode && sync_mode)) ##1
      (s_clean_step and (sleep_mode && sync_mode)) |=> $stable(st_q.cnt))
    else $error("synchronised count advanced in sleep");

  a_capture_clear: assert property ( // [R15]
    (capture_clear && !cnt_wr) |=> st_q.cnt == CNT_ZERO)
    else $error("capture trigger did not clear count");

  a_write_wins: assert property ( // [R20]
    (wr_lo && capture_clear) |=> st_q.cnt[7:0] == $past(pwdata[7:0]))
    else $error("count write lost to capture clear");

  a_write_drops_inc: assert property ( // [R21]
    (wr_hi && !wr_lo) |=> st_q.cnt[7:0] == $past(st_q.cnt[7:0]))
    else $error("count byte write let an increment through");

  a_tbase_flag: assert property ( // [R14]
    (st_q.ctl.clock_source_select && st_q.ctl.no_sync_select) |-> !timebase_valid)
    else $error("unsynchronised count offered as time base");

  a_ctl_top_zero: assert property ( // [R16]
    (setup && paddr == ADR_CTL) |=> prdata[7:6] == 2'b00 && pready)
    else $error("control upper bits not zero on read");

endmodule

`default_nettype wire

// ==== tb/stc_ext_src.sv ====
// Purpose: Far-side clock source: external clock pin and crystal oscillator input
// Assumes: Edges are launched just after a pclk rising edge
// Notes:   Both lines rest low between bursts; the source does not run free
`timescale 1ns/10ps
`default_nettype none

module stc_ext_src (
  input  wire logic pclk,
  output var  logic ext_clock_pin,
  output var  logic osc_input_pin
);
  initial begin
    ext_clock_pin = 1'b0;
    osc_input_pin = 1'b0;
  end

  // Half period in pclk; 2 or more keeps the sync sampler able to see each level
  task automatic pulses(input bit use_osc, input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge pclk);
      if (use_osc) osc_input_pin <= 1'b1;
      else ext_clock_pin <= 1'b1;
      repeat (half) @(posedge pclk);
      if (use_osc) osc_input_pin <= 1'b0;
      else ext_clock_pin <= 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// ==== tb/test_sixteen_bit_timer_counter.sv ====
// Purpose: Self-checking bench for the 16-bit timer/counter over APB
// Assumes: One-cycle APB access; count has no reset so it is loaded first
// Notes:   Count deltas are taken from the count port between two edges
`timescale 1ns/10ps
`default_nettype none

module test_sixteen_bit_timer_counter;
  import stc_pkg::*;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic              sleep_mode = 0, capture_clear = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, rdat;
  logic [1:0]        port_dir_oe = 2'b11;
  logic              rerr;
  logic [CNT_W-1:0]  t0;
  wire  logic [31:0] prdata;
  wire  logic        pready, pslverr, timebase_valid, irq_req, wake_req;
  wire  logic        ext_clock_pin, osc_input_pin;
  wire  logic [15:0] count_value;
  wire  logic [1:0]  osc_pin_oe;
  int                err_count = 0, n_checks = 0, cyc = 0, n;

  always #5 pclk = ~pclk;

  stc_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clock_pin(ext_clock_pin), .osc_input_pin(osc_input_pin),
    .port_dir_oe(port_dir_oe), .sleep_mode(sleep_mode), .capture_clear(capture_clear),
    .count_value(count_value), .timebase_valid(timebase_valid), .irq_req(irq_req),
    .wake_req(wake_req), .osc_pin_oe(osc_pin_oe));
  stc_ext_src src (.pclk(pclk), .ext_clock_pin(ext_clock_pin),
    .osc_input_pin(osc_input_pin));

  task automatic report_and_stop;
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      report_and_stop;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Entered just after a rising edge; the capture clear rides along with the access phase
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic c);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1; capture_clear <= c;
    // Waits as long as the slave takes; only the bench timeout ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata; rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0; capture_clear <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000, 1'b0);
    chk(nm, rdat, e);
  endtask

  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADR_CTL, 32'h0000_0000, "ctl_reset");
    apb(1'b0, 12'h004, 32'h0000_0000, 1'b0);
    chk("unmapped_err", 32'(rerr), 32'h0000_0001);
    wr(ADR_CTL, 32'h0000_00FF);
    rd(ADR_CTL, 32'h0000_003F, "ctl_rw");
    chk("osc_oe_forced", 32'(osc_pin_oe), 32'h0000_0000);
    wr(ADR_CTL, 32'h0000_0000);
    settle;
    chk("osc_oe_dir", 32'(osc_pin_oe), 32'h0000_0003);
    apb(1'b1, ADR_CNT_LO, 32'h0000_00FE, 1'b1);
    wr(ADR_CNT_HI, 32'h0000_00FF);
    rd(ADR_CNT_LO, 32'h0000_00FE, "write_beats_clear");
    repeat (40) @(posedge pclk);
    chk("stopped_hold", 32'(count_value), 32'h0000_FFFE);
    wr(ADR_IEN, 32'h0000_0001);
    wr(ADR_CTL, 32'h0000_0001);
    n = 0;
    while (irq_req !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("wrap_count", 32'(count_value), 32'h0000_0000);
    rd(ADR_FLAG, 32'h0000_0001, "flag_set");
    wr(ADR_CTL, 32'h0000_0000);
    wr(ADR_IEN, 32'h0000_0000);
    settle;
    chk("irq_masked", 32'(irq_req), 32'h0000_0000);
    wr(ADR_FLAG, 32'h0000_0000);
    rd(ADR_FLAG, 32'h0000_0000, "flag_clear");
    // Any window of 8*div ticks holds exactly 8 prescaler outputs
    for (int k = 0; k < 4; k++) begin
      wr(ADR_CTL, 32'(k * 16 + 1));
      wr(ADR_CNT_LO, 32'h0000_0000);
      t0 = count_value;
      repeat (32 << k) @(posedge pclk);
      chk("prescale", 32'(16'(count_value - t0)), 32'h0000_0008);
    end
    wr(ADR_CTL, 32'h0000_0003);
    t0 = count_value;
    src.pulses(0, 5, 3);
    src.pulses(1, 4, 3);
    settle;
    chk("ext_pin_count", 32'(16'(count_value - t0)), 32'h0000_0005);
    wr(ADR_CTL, 32'h0000_000B);
    t0 = count_value;
    src.pulses(1, 3, 7);
    src.pulses(0, 2, 3);
    settle;
    chk("osc_pin_count", 32'(16'(count_value - t0)), 32'h0000_0003);
    chk("osc_oe_inputs", 32'(osc_pin_oe), 32'h0000_0000);
    wr(ADR_CTL, 32'h0000_0033);
    wr(ADR_CNT_LO, 32'h0000_0000);
    t0 = count_value;
    sleep_mode <= 1'b1;
    src.pulses(0, 3, 3);
    settle;
    chk("sleep_frozen", 32'(16'(count_value - t0)), 32'h0000_0000);
    sleep_mode <= 1'b0;
    src.pulses(0, 1, 3);
    settle;
    chk("sleep_prescaled", 32'(16'(count_value - t0)), 32'h0000_0001);
    wr(ADR_CNT_LO, 32'h0000_0000);
    t0 = count_value;
    src.pulses(0, 3, 3);
    settle;
    chk("pre_cleared_a", 32'(16'(count_value - t0)), 32'h0000_0000);
    src.pulses(0, 1, 3);
    settle;
    chk("pre_cleared_b", 32'(16'(count_value - t0)), 32'h0000_0001);
    wr(ADR_CTL, 32'h0000_0000);
    wr(ADR_CNT_LO, 32'h0000_00FE);
    wr(ADR_CNT_HI, 32'h0000_00FF);
    wr(ADR_FLAG, 32'h0000_0000);
    wr(ADR_IEN, 32'h0000_0001);
    wr(ADR_CTL, 32'h0000_0007);
    sleep_mode <= 1'b1;
    src.pulses(0, 3, 3);
    settle;
    chk("async_sleep_cnt", 32'(count_value), 32'h0000_0001);
    chk("wake", 32'(wake_req), 32'h0000_0001);
    chk("timebase_off", 32'(timebase_valid), 32'h0000_0000);
    sleep_mode <= 1'b0;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    chk("cnt_survives_rst", 32'(count_value), 32'h0000_0001);
    rd(ADR_CTL, 32'h0000_0000, "ctl_rst_again");
    chk("timebase_on", 32'(timebase_valid), 32'h0000_0001);
    capture_clear <= 1'b1;
    @(posedge pclk);
    capture_clear <= 1'b0;
    settle;
    chk("capture_clear", 32'(count_value), 32'h0000_0000);
    report_and_stop;
  end
endmodule

`default_nettype wire
